// file: pxr_pkg.sv
// Package: register map, field positions and reset values of the extended status bank
package pxr_pkg;
  localparam logic [5:0]  IDX_CAP      = 6'h12;
  localparam logic [5:0]  IDX_ENTROPY  = 6'h13;
  localparam logic [5:0]  IDX_IRQ_MASK = 6'h1C;
  localparam logic [5:0]  IDX_IRQ_STAT = 6'h1D;
  localparam logic [5:0]  IDX_RING     = 6'h1E;
  localparam logic [5:0]  IDX_IRQ_CLR  = 6'h20;
  localparam logic [5:0]  IDX_RING_IN  = 6'h21;
  localparam logic [15:0] IRQ_BITS     = 16'h041F;
  localparam int          IRQ_MEM      = 10;
  localparam int          IRQ_SWITCH   = 4;
  localparam int          IRQ_EEE_LINK = 3;
  localparam int          IRQ_EEE_TQ   = 2;
  localparam int          IRQ_EEE_TS   = 1;
  localparam int          IRQ_EEE_WAKE = 0;
  localparam int          CAP_PTP      = 13;
  localparam int          CAP_HIPREC   = 9;
  localparam int          RING_START   = 15;
  localparam int          RING_ADV     = 14;
  localparam int          RING_LP_ADV  = 13;
  localparam int          RING_FORCE   = 12;
  localparam int          RING_ROLE_LO = 4;
  localparam int          RING_GO      = 0;
  localparam logic [15:0] RING_WMASK   = 16'hD000;
  localparam logic [15:0] LFSR_SEED    = 16'hACE1;
  localparam logic [15:0] LFSR_TAPS    = 16'hB400;
  localparam logic [1:0]  ROLE_SLAVE   = 2'b00;
  localparam logic [1:0]  ROLE_TO_MSTR = 2'b10;
  localparam logic [1:0]  ROLE_MASTER  = 2'b11;
  localparam logic [1:0]  ROLE_TO_SLV  = 2'b01;
  localparam int          SWITCH_CYC   = 4;
  localparam logic [7:0]  CHIP_VARIANT = 8'h5A; // Arbitrary value
endpackage

// file: pxr_regs.sv
// Extended capability, entropy, interrupt and ring failover registers on APB
// What this block does
// - Capability bit 13 reads one when time protocol operation is supported.
// - Capability bit 9 reads high-precision timestamp support; writes ignored.
// - Entropy register returns fresh random bits on 15:0.
// - Mask bits 10,4..0 enable events, reset zero, survive soft reset.
// - Status bits 10,4..0 read one while pending, read-only, clear on read.
// - Status bits 3..0: link fail, quiet timer, sleep timer, wake error.
// - Status bit 10 pends on memory integrity ring event.
// - Status bit 4 pends when role switchover finishes.
// - Role field 5:4: 00 slave, 10 to master, 11 master, 01 to slave.
// - Only at first link-up does steady role take autonegotiation outcome.
// - Writing bit 0 starts a switchover and self-clears; only when idle.
// - Bit 12 forces failover; bit 14 advertises; bit 15 startup master.
// - Bit 13 shows link partner failover advertisement, reset zero.
//
// The APB slave port was left to the implementer.
`timescale 1ns/1ps
module pxr_regs #(
  parameter bit         PTP_CAPABLE    = 1'b1,
  parameter bit         HIPREC_CAPABLE = 1'b1,
  parameter logic [7:0] VARIANT_CODE   = pxr_pkg::CHIP_VARIANT // Arbitrary value
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        soft_reset,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        eee_link_fail,
  input  wire logic        eee_rx_quiet_exp,
  input  wire logic        eee_rx_sleep_exp,
  input  wire logic        eee_wake_err,
  input  wire logic        mem_ring_event,
  input  wire logic        link_up,
  input  wire logic        aneg_master,
  input  wire logic        link_partner_adv,
  output logic             ring_failover_force,
  output logic             ring_failover_adv,
  output logic             ring_failover_start_master,
  output logic             irq
);
  typedef enum logic [1:0] {
    ROLE_SLV_S  = pxr_pkg::ROLE_SLAVE,
    ROLE_UP_S   = pxr_pkg::ROLE_TO_MSTR,
    ROLE_MST_S  = pxr_pkg::ROLE_MASTER,
    ROLE_DOWN_S = pxr_pkg::ROLE_TO_SLV
  } pxr_role_t;

  typedef struct packed {
    logic [15:0] mask;
    logic [15:0] stat;
    logic [15:0] lfsr;
    logic [15:0] ring;
    pxr_role_t   role;
    logic        linked;
    logic [2:0]  sw_cnt;
    logic        lp_adv;
    logic [31:0] rdata;
    logic        slverr;
  } pxr_state_t;

  pxr_state_t s_q;
  pxr_state_t s_d;

  function automatic logic hit(input logic [31:0] a, input logic [5:0] idx);
    hit = (a[31:2] == {24'h000000, idx}) && (a[1:0] == 2'b00);
  endfunction

  function automatic logic in_switch(input pxr_role_t r);
    in_switch = (r == ROLE_UP_S) || (r == ROLE_DOWN_S);
  endfunction

  logic        setup_ph;
  logic        wr_acc;
  logic        rd_acc;
  logic        full_lanes;
  logic        sel_cap;
  logic        sel_ent;
  logic        sel_mask;
  logic        sel_stat;
  logic        sel_ring;
  logic        sel_clr;
  logic        sel_spare;
  logic        mapped;
  logic        sw_done;
  logic        go_ok;
  logic        linked_nxt;
  logic [2:0]  cnt_nxt;
  logic [15:0] ev;
  logic [15:0] cap;
  logic [15:0] ring_view;
  logic [15:0] rd_word;
  logic [15:0] lfsr_nxt;
  logic [15:0] mask_nxt;
  logic [15:0] stat_nxt;
  logic [15:0] ring_nxt;
  pxr_role_t   role_nxt;

  assign setup_ph   = psel && !penable;
  assign wr_acc     = psel && penable && pwrite;
  assign rd_acc     = psel && penable && !pwrite;
  assign full_lanes = (pstrb[1:0] == 2'b11);
  assign sel_cap    = hit(paddr, pxr_pkg::IDX_CAP);
  assign sel_ent    = hit(paddr, pxr_pkg::IDX_ENTROPY);
  assign sel_mask   = hit(paddr, pxr_pkg::IDX_IRQ_MASK);
  assign sel_stat   = hit(paddr, pxr_pkg::IDX_IRQ_STAT);
  assign sel_ring   = hit(paddr, pxr_pkg::IDX_RING);
  assign sel_clr    = hit(paddr, pxr_pkg::IDX_IRQ_CLR);
  assign sel_spare  = hit(paddr, pxr_pkg::IDX_RING_IN);
  assign mapped     = sel_cap || sel_ent || sel_mask || sel_stat
                      || sel_ring || sel_clr || sel_spare;
  assign sw_done    = in_switch(s_q.role)
                      && (s_q.sw_cnt == 3'(pxr_pkg::SWITCH_CYC - 1));
  assign go_ok      = !in_switch(s_q.role) && !s_q.ring[pxr_pkg::RING_GO];
  // Always ready: read data is captured in the setup phase and stands in the access phase
  assign pready     = 1'b1;
  assign prdata     = s_q.rdata;
  assign pslverr    = s_q.slverr;

  always_comb begin
    cap = 16'h0000;
    cap[pxr_pkg::CAP_PTP] = PTP_CAPABLE;
    cap[pxr_pkg::CAP_HIPREC] = HIPREC_CAPABLE;
    cap[7:0] = VARIANT_CODE;
    ev = 16'h0000;
    ev[pxr_pkg::IRQ_EEE_LINK] = eee_link_fail;
    ev[pxr_pkg::IRQ_EEE_TQ] = eee_rx_quiet_exp;
    ev[pxr_pkg::IRQ_EEE_TS] = eee_rx_sleep_exp;
    ev[pxr_pkg::IRQ_EEE_WAKE] = eee_wake_err;
    ev[pxr_pkg::IRQ_MEM] = mem_ring_event;
    ev[pxr_pkg::IRQ_SWITCH] = sw_done;
  end

  // Ring register as software sees it
  always_comb begin
    ring_view = s_q.ring;
    ring_view[pxr_pkg::RING_LP_ADV] = s_q.lp_adv;
    ring_view[pxr_pkg::RING_ROLE_LO +: 2] = s_q.role;
  end

  // Read multiplexer, unmapped words read zero
  always_comb begin
    rd_word = 16'h0000;
    if (sel_cap) begin
      rd_word = cap;
    end else if (sel_ent) begin
      rd_word = s_q.lfsr;
    end else if (sel_mask) begin
      rd_word = s_q.mask;
    end else if (sel_stat) begin
      rd_word = s_q.stat;
    end else if (sel_ring) begin
      rd_word = ring_view;
    end
  end

  // Entropy source steps on every clock
  always_comb begin
    lfsr_nxt = s_q.lfsr >> 1;
    if (s_q.lfsr[0]) begin
      lfsr_nxt = lfsr_nxt ^ pxr_pkg::LFSR_TAPS;
    end
  end

  // Mask survives soft reset
  always_comb begin
    mask_nxt = s_q.mask;
    if (wr_acc && full_lanes && sel_mask) begin
      mask_nxt = pwdata[15:0] & pxr_pkg::IRQ_BITS;
    end
  end

  // Status read clears only the bits it returned; a new event wins over a clear but not over soft reset
  always_comb begin
    stat_nxt = s_q.stat;
    if (rd_acc && sel_stat) begin
      stat_nxt = s_q.stat & ~s_q.rdata[15:0];
    end
    if (wr_acc && full_lanes && sel_clr) begin
      stat_nxt = s_q.stat & ~pwdata[15:0];
    end
    stat_nxt = stat_nxt | (ev & pxr_pkg::IRQ_BITS);
    if (soft_reset) begin
      stat_nxt = 16'h0000;
    end
  end

  // Ring controls; the start bit lives one cycle
  always_comb begin
    ring_nxt = s_q.ring;
    ring_nxt[pxr_pkg::RING_GO] = 1'b0;
    if (wr_acc && full_lanes && sel_ring) begin
      ring_nxt = pwdata[15:0] & pxr_pkg::RING_WMASK;
      ring_nxt[pxr_pkg::RING_GO] = pwdata[pxr_pkg::RING_GO] && go_ok;
    end
    if (soft_reset) begin
      ring_nxt[pxr_pkg::RING_GO] = 1'b0;
    end
  end

  // Timing role machine
  always_comb begin
    role_nxt = s_q.role;
    cnt_nxt = s_q.sw_cnt;
    linked_nxt = s_q.linked || link_up;
    unique case (s_q.role)
      ROLE_SLV_S: begin
        if (s_q.ring[pxr_pkg::RING_GO]) begin
          role_nxt = ROLE_UP_S;
        end else if (link_up && !s_q.linked && aneg_master) begin
          role_nxt = ROLE_MST_S;
        end
      end
      ROLE_UP_S: begin
        cnt_nxt = s_q.sw_cnt + 3'h1;
        if (sw_done) begin
          role_nxt = ROLE_MST_S;
          cnt_nxt = 3'h0;
        end
      end
      ROLE_MST_S: begin
        if (s_q.ring[pxr_pkg::RING_GO]) begin
          role_nxt = ROLE_DOWN_S;
        end else if (link_up && !s_q.linked && !aneg_master) begin
          role_nxt = ROLE_SLV_S;
        end
      end
      ROLE_DOWN_S: begin
        cnt_nxt = s_q.sw_cnt + 3'h1;
        if (sw_done) begin
          role_nxt = ROLE_SLV_S;
          cnt_nxt = 3'h0;
        end
      end
    endcase
    if (soft_reset) begin
      role_nxt = ROLE_SLV_S;
      cnt_nxt = 3'h0;
      linked_nxt = s_q.linked;
    end
  end

  // Next state; read data and error are taken at the setup edge
  always_comb begin
    s_d = s_q;
    s_d.mask = mask_nxt;
    s_d.stat = stat_nxt;
    s_d.lfsr = lfsr_nxt;
    s_d.ring = ring_nxt;
    s_d.role = role_nxt;
    s_d.linked = linked_nxt;
    s_d.sw_cnt = cnt_nxt;
    s_d.lp_adv = link_partner_adv;
    s_d.slverr = 1'b0;
    if (setup_ph) begin
      s_d.slverr = !mapped;
      if (!pwrite) begin
        s_d.rdata = {16'h0000, rd_word};
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '{mask:   16'h0000,
               stat:   16'h0000,
               lfsr:   pxr_pkg::LFSR_SEED,
               ring:   16'h0000,
               role:   ROLE_SLV_S,
               linked: 1'b0,
               sw_cnt: 3'h0,
               lp_adv: 1'b0,
               rdata:  32'h0000_0000,
               slverr: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  assign ring_failover_force = s_q.ring[pxr_pkg::RING_FORCE];
  assign ring_failover_adv = s_q.ring[pxr_pkg::RING_ADV];
  assign ring_failover_start_master = s_q.ring[pxr_pkg::RING_START];
  assign irq = |(s_q.stat & s_q.mask);
endmodule // pxr_regs

// file: pxr_checker.sv
// Concurrent checks on the ports of the extended status bank
`timescale 1ns/1ps
module pxr_checker #(
  parameter bit PTP_CAPABLE    = 1'b1,
  parameter bit HIPREC_CAPABLE = 1'b1
) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  input wire logic        eee_link_fail,
  input wire logic        eee_rx_quiet_exp,
  input wire logic        eee_rx_sleep_exp,
  input wire logic        eee_wake_err,
  input wire logic        mem_ring_event,
  input wire logic        link_partner_adv,
  input wire logic        ring_failover_force,
  input wire logic        ring_failover_adv,
  input wire logic        ring_failover_start_master,
  input wire logic        irq
);
  logic acc, wr_ok, rd, ev;
  logic [2:0] ctl;
  assign acc = psel & penable;
  assign wr_ok = acc & pwrite & (pstrb[1:0] == 2'h3);
  assign rd = acc & !pwrite;
  assign ev = eee_link_fail | eee_rx_quiet_exp | eee_rx_sleep_exp | eee_wake_err | mem_ring_event;
  assign ctl = {ring_failover_start_master, ring_failover_adv, ring_failover_force};
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_ctrl_write: assert property (wr_ok && paddr == 32'h78 |=>
    ctl == {$past(pwdata[15]), $past(pwdata[14]), $past(pwdata[12])}) else $error("ctrl write");
  chk_ctrl_hold: assert property (!(wr_ok && paddr == 32'h78) |=> $stable(ctl))
    else $error("ctrl changed");
  chk_cap_ptp: assert property (rd && paddr == 32'h48 |-> prdata[13] == PTP_CAPABLE)
    else $error("cap ptp bit");
  chk_cap_hiprec: assert property (rd && paddr == 32'h48 |-> prdata[9] == HIPREC_CAPABLE)
    else $error("cap precision bit");
  chk_read_clears: assert property (rd && paddr == 32'h74 && !ev && !$past(ev) |=> !irq)
    else $error("irq after status read");
  chk_mask_zero: assert property (wr_ok && paddr == 32'h70 &&
    (pwdata[15:0] & pxr_pkg::IRQ_BITS) == 16'h0000 |=> !irq) else $error("irq with mask off");
  chk_lp_adv: assert property (rd && paddr == 32'h78 |->
    prdata[13] == $past(link_partner_adv, 2)) else $error("partner adv bit");
  chk_bad_addr: assert property (acc && !(paddr inside {32'h48, 32'h4C, 32'h70, 32'h74, 32'h78,
    32'h80, 32'h84}) |-> pslverr) else $error("no error on unmapped");
endmodule // pxr_checker
bind pxr_regs pxr_checker #(.PTP_CAPABLE(PTP_CAPABLE), .HIPREC_CAPABLE(HIPREC_CAPABLE)) u_chk (.*);

// file: tb_top.sv
// Directed testbench of the extended status bank
`timescale 1ns/1ps
module tb_top;
  logic        pclk = 1'h0, presetn = 1'h0, soft_reset = 1'h0, psel = 1'h0, penable = 1'h0;
  logic        pwrite = 1'h0, link_up = 1'h0, aneg_master = 1'h1, link_partner_adv = 1'h0;
  logic [31:0] paddr = '0, pwdata = '0, prdata, r, x;
  logic [3:0]  pstrb = 4'hF;
  logic [4:0]  ev = '0;
  logic        pready, pslverr, irq, e;
  logic        ring_failover_force, ring_failover_adv, ring_failover_start_master;
  int          n_fail = 0, comparisons = 0, cyc = 0;
  pxr_regs DUT (.*, .eee_link_fail(ev[3]), .eee_rx_quiet_exp(ev[2]), .eee_rx_sleep_exp(ev[1]),
    .eee_wake_err(ev[0]), .mem_ring_event(ev[4]));
  always #2.5 pclk = ~pclk;
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      test_done();
    end
  end
  task automatic chk(input string s, input logic [32:0] xp, input logic [32:0] g);
    comparisons++;
    if (g !== xp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", s, xp, g);
    end
  endtask
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk) penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    r = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask
  task automatic t_reset();
    chk("outputs", 4'h0, {irq, ring_failover_force, ring_failover_adv, ring_failover_start_master});
    apb(1'h0, 32'h70, '0);
    chk("mask reset", 32'h0, r);
    apb(1'h0, 32'h78, '0);
    chk("ring reset", 32'h0, r);
  endtask
  task automatic t_cap();
    apb(1'h1, 32'h48, '0);
    apb(1'h0, 32'h48, '0);
    chk("cap", {1'h0, 32'h2200 | pxr_pkg::CHIP_VARIANT}, {e, r & 32'hFFFF3BFF});
    apb(1'h0, 32'h40, '0);
    chk("unmapped", 1'h1, e);
  endtask
  task automatic t_entropy();
    apb(1'h0, 32'h4C, '0);
    x = r;
    apb(1'h0, 32'h4C, '0);
    chk("entropy", 17'h1, {r[31:16], r[15:0] !== x[15:0]});
  endtask
  task automatic t_events();
    apb(1'h1, 32'h70, 32'h041F);
    for (int k = 0; k < 5; k++) begin
      ev <= 5'h01 << k;
      @(posedge pclk) ev <= '0;
      @(posedge pclk) chk("irq set", 1'h1, irq);
      apb(1'h0, 32'h74, '0);
      chk("status", (k == 4) ? 32'h400 : (32'h1 << k), r);
      apb(1'h0, 32'h74, '0);
      chk("cleared", 33'h0, {irq, r});
    end
    apb(1'h1, 32'h70, '0);
    ev <= 5'h10;
    @(posedge pclk) ev <= '0;
    @(posedge pclk) chk("masked irq", 1'h0, irq);
    apb(1'h0, 32'h74, '0);
    chk("masked", 32'h400, r);
    ev <= 5'h01;
    @(posedge pclk) ev <= '0;
    apb(1'h1, 32'h80, 32'h1);
    apb(1'h0, 32'h74, '0);
    chk("clear reg", 32'h0, r);
    apb(1'h1, 32'h70, 32'h041F);
    soft_reset <= 1'h1;
    @(posedge pclk) soft_reset <= 1'h0;
    apb(1'h0, 32'h70, '0);
    chk("mask kept", 32'h041F, r);
  endtask
  task automatic t_ring();
    apb(1'h1, 32'h78, 32'hD000);
    chk("ctrl", 3'h7, {ring_failover_start_master, ring_failover_adv, ring_failover_force});
    soft_reset <= 1'h1;
    link_partner_adv <= 1'h1;
    @(posedge pclk) soft_reset <= 1'h0;
    link_up <= 1'h1;
    repeat (4) @(posedge pclk);
    apb(1'h0, 32'h78, '0);
    chk("master", 32'hF030, r);
    apb(1'h1, 32'h78, 32'hD001);
    apb(1'h0, 32'h78, '0);
    chk("to slave", 32'hF010, r);
    repeat (8) @(posedge pclk);
    apb(1'h0, 32'h78, '0);
    chk("slave", 32'hF000, r);
    apb(1'h0, 32'h74, '0);
    chk("switch done", 32'h10, r);
    apb(1'h1, 32'h78, 32'hD001);
    apb(1'h1, 32'h78, 32'hD001);
    repeat (8) @(posedge pclk);
    apb(1'h0, 32'h78, '0);
    chk("refused", 32'hF030, r);
  endtask
  task automatic test_done();
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    t_reset();
    t_cap();
    t_entropy();
    t_events();
    t_ring();
    test_done();
  end
endmodule // tb_top
